/* File: verilog/rfch_top.v */
// Our own choices: the APB slave port and the register addresses.
`timescale 1ns/10ps
`include "rfch_map.vh"
module rfch_top #(
  parameter SLOT_W = 2,
  parameter REC_W = 5,
  parameter LEN_W = 6
) (
  // Clock and reset
  input wire clk_sys,
  input wire resetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr
);
  localparam NSLOT = 1 << SLOT_W;
  localparam MAXLEN = 1 << (LEN_W - 1);
  localparam MAXREC = 1 << (REC_W - 1);
  localparam SAW = REC_W + LEN_W - 2;
  localparam AW = SLOT_W + SAW;
  localparam [REC_W-1:0] REC1 = 1;
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_DEC = 3'h1;
  localparam [2:0] S_XFER = 3'h2;
  localparam [2:0] S_SREC = 3'h3;
  localparam [2:0] S_SFIND = 3'h4;
  localparam [2:0] S_SCMP = 3'h5;
  localparam [2:0] S_DONE = 3'h6;

  reg rstMeta;
  reg rstSync;
  wire rstn;
  reg [2:0] state;
  reg busy;
  reg [1:0] cmd;
  reg [7:0] p1;
  reg [7:0] p2;
  reg [LEN_W-1:0] lc;
  reg [7:0] le;
  reg leValid;
  reg [1:0] soMode;
  reg [7:0] soVal;
  reg [SLOT_W-1:0] sel;
  reg [REC_W-1:0] ptr;
  reg ptrSet;
  reg [2:0] result;
  reg [LEN_W-1:0] respLen;
  reg [REC_W-1:0] curRec;
  reg [REC_W-1:0] pend;
  reg pendMove;
  reg [LEN_W-1:0] xLen;
  reg [LEN_W-1:0] sPos;
  reg [LEN_W-1:0] j;
  reg [SAW-1:0] binOff;
  reg [4:0] cfgSfi [0:NSLOT-1];
  reg [1:0] cfgType [0:NSLOT-1];
  reg cfgRd [0:NSLOT-1];
  reg cfgUp [0:NSLOT-1];
  reg [REC_W-1:0] cfgNrec [0:NSLOT-1];
  reg [LEN_W-1:0] cfgLen [0:NSLOT-1];
  reg [REC_W-2:0] head [0:NSLOT-1];
  reg [7:0] dbuf [0:MAXLEN-1];
  reg [7:0] rbuf [0:MAXLEN-1];
  integer i;
  integer k;

  ////////////////////////////////////////////////////////////////////////////////
  // Reset release
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end
  assign rstn = rstSync;

  ////////////////////////////////////////////////////////////////////////////////
  // APB decode
  wire apbAcc = psel & penable & ~pready;
  wire wrEv = psel & penable & pready & pwrite & ~pslverr;
  wire [LEN_W-2:0] bufIx = paddr[LEN_W:2];
  wire inWin = (paddr[9:LEN_W+1] == 0) && (paddr[1:0] == 2'h0);
  wire inDbuf = ((paddr & `RFCH_A_WIN) == `RFCH_A_DBUF) && inWin;
  wire inRbuf = ((paddr & `RFCH_A_WIN) == `RFCH_A_RBUF) && inWin;
  wire isReg = (paddr == `RFCH_A_CTRL) || (paddr == `RFCH_A_PARAM) ||
    (paddr == `RFCH_A_LEN) || (paddr == `RFCH_A_SRCH) || (paddr == `RFCH_A_SEL) ||
    (paddr == `RFCH_A_FCFG) || (paddr == `RFCH_A_STAT);
  // Config is frozen while a command runs so the engine sees stable inputs
  wire apbErr = ~(isReg | inDbuf | inRbuf) |
    (pwrite & (busy | inRbuf | (paddr == `RFCH_A_STAT)));
  reg [31:0] rdv;

  always @* begin
    rdv = `RFCH_RST_WORD;
    case (paddr)
      `RFCH_A_CTRL: rdv[`RFCH_CTRL_CMD +: 2] = cmd;
      `RFCH_A_PARAM: begin
        rdv[7:0] = p1;
        rdv[`RFCH_PAR_P2 +: 8] = p2;
      end
      `RFCH_A_LEN: begin
        rdv[LEN_W-1:0] = lc;
        rdv[`RFCH_LEN_LE +: 8] = le;
        rdv[`RFCH_LEN_LEV] = leValid;
      end
      `RFCH_A_SRCH: begin
        rdv[1:0] = soMode;
        rdv[`RFCH_SR_VAL +: 8] = soVal;
      end
      `RFCH_A_SEL: rdv[SLOT_W-1:0] = sel;
      `RFCH_A_FCFG: begin
        rdv[4:0] = cfgSfi[sel];
        rdv[`RFCH_FC_TYPE +: 2] = cfgType[sel];
        rdv[`RFCH_FC_RD] = cfgRd[sel];
        rdv[`RFCH_FC_UP] = cfgUp[sel];
        rdv[`RFCH_FC_NREC +: REC_W] = cfgNrec[sel];
        rdv[`RFCH_FC_LEN +: LEN_W] = cfgLen[sel];
        rdv[`RFCH_FC_SLOT +: SLOT_W] = sel;
      end
      `RFCH_A_STAT: begin
        rdv[`RFCH_ST_BUSY] = busy;
        rdv[`RFCH_ST_RES +: 3] = result;
        rdv[`RFCH_ST_PSET] = ptrSet;
        rdv[`RFCH_ST_PTR +: REC_W] = ptr;
        rdv[`RFCH_ST_RLEN +: LEN_W] = respLen;
        rdv[`RFCH_ST_SEL +: SLOT_W] = sel;
      end
      default: begin
        if (inRbuf) begin
          rdv[7:0] = rbuf[bufIx];
        end else if (inDbuf) begin
          rdv[7:0] = dbuf[bufIx];
        end
      end
    endcase
  end

  // One wait state: answer registered in the first access cycle
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= `RFCH_RST_WORD;
    end else begin
      pready <= apbAcc;
      pslverr <= apbAcc & apbErr;
      if (apbAcc) begin
        prdata <= apbErr ? `RFCH_RST_WORD : rdv;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // File resolution and mode decode
  wire binSfi = (p1[7:5] == `RFCH_BIN_SFI);
  wire [4:0] reqSfi = (cmd == `RFCH_CMD_UPBIN) ? (binSfi ? p1[4:0] : `RFCH_SFI_CUR) :
    p2[7:3];
  wire [14:0] binOffRaw = binSfi ? {7'h00, p2} : {p1[6:0], p2};
  reg hit;
  reg [SLOT_W-1:0] hitSlot;

  always @* begin
    hit = 1'b0;
    hitSlot = sel;
    for (i = 0; i < NSLOT; i = i + 1) begin
      if (!hit && cfgSfi[i] == reqSfi) begin
        hit = 1'b1;
        hitSlot = i[SLOT_W-1:0];
      end
    end
  end

  wire [SLOT_W-1:0] tSlot = (reqSfi == `RFCH_SFI_CUR) ? sel : hitSlot;
  wire [1:0] tType = cfgType[tSlot];
  wire [REC_W-1:0] tNrec = cfgNrec[tSlot];
  wire isCyc = (tType == `RFCH_FT_CYC);
  wire ptrValid = ptrSet & (tSlot == sel);
  wire [2:0] mode = p2[2:0];
  wire [REC_W-2:0] headDec = (head[tSlot] == 0) ? (tNrec[REC_W-2:0] - 1'b1) :
    (head[tSlot] - 1'b1);
  reg [2:0] dRes;
  reg [REC_W-1:0] dRec;
  reg dMove;
  reg [LEN_W-1:0] dLen;

  always @* begin
    dRes = `RFCH_R_OK;
    dRec = ptr;
    dMove = 1'b0;
    dLen = cfgLen[tSlot];
    case (mode)
      `RFCH_M_NEXT: begin
        dMove = 1'b1;
        if (!ptrValid) begin
          dRec = REC1;
        end else if (ptr == tNrec) begin
          dRec = REC1;
          if (!isCyc) begin
            dRes = `RFCH_R_NODATA;
          end
        end else begin
          dRec = ptr + REC1;
        end
      end
      `RFCH_M_PREV: begin
        dMove = 1'b1;
        if (!ptrValid || ptr == REC1) begin
          dRec = tNrec;
          if (ptrValid && !isCyc) begin
            dRes = `RFCH_R_NODATA;
          end
        end else begin
          dRec = ptr - REC1;
        end
      end
      `RFCH_M_ABS: begin
        if (p1 == 8'h00) begin
          if (!ptrValid) begin
            dRes = `RFCH_R_BADP;
          end
        end else if (p1 > tNrec) begin
          dRes = `RFCH_R_BADP;
        end else begin
          dRec = p1[REC_W-1:0];
        end
      end
      default: dRes = `RFCH_R_BADP;
    endcase
    if (cmd == `RFCH_CMD_SRCH) begin
      dMove = 1'b0;
      dRec = p1[REC_W-1:0];
      dRes = `RFCH_R_OK;
      if ((mode != `RFCH_M_FWD && mode != `RFCH_M_BWD) || p1 == 8'h00 || p1 > tNrec ||
          lc == 0 || lc > dLen) begin
        dRes = `RFCH_R_BADP;
      end
    end else if (cmd == `RFCH_CMD_UPREC && isCyc) begin
      dRec = REC1;
      dMove = 1'b1;
      dRes = (mode == `RFCH_M_PREV) ? `RFCH_R_OK : `RFCH_R_BADP;
    end
    if (cmd == `RFCH_CMD_UPREC && lc != dLen) begin
      dRes = `RFCH_R_BADP;
    end
    if (cmd != `RFCH_CMD_UPBIN && (tNrec == 0 || tNrec > MAXREC || dLen > MAXLEN)) begin
      dRes = `RFCH_R_BADP;
    end
    if (cmd == `RFCH_CMD_UPBIN) begin
      dMove = 1'b0;
      dLen = lc;
      dRes = `RFCH_R_OK;
      if ((p1[7] & ~binSfi) || lc > MAXLEN || binOffRaw + lc > (1 << SAW)) begin
        dRes = `RFCH_R_BADP;
      end
    end
    if ((cmd == `RFCH_CMD_UPBIN) != (tType == `RFCH_FT_TRANS) || tType == 2'h3) begin
      dRes = `RFCH_R_WSTRUCT;
    end
    if ((cmd == `RFCH_CMD_RDREC || cmd == `RFCH_CMD_SRCH) ? ~cfgRd[tSlot] : ~cfgUp[tSlot]) begin
      dRes = `RFCH_R_DENIED;
    end
    if (reqSfi != `RFCH_SFI_CUR && !hit) begin
      dRes = `RFCH_R_NOFILE;
    end
    if (cmd != `RFCH_CMD_UPBIN && reqSfi == `RFCH_SFI_RFU) begin
      dRes = `RFCH_R_BADP;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Record store
  wire [REC_W-1:0] physSum = {1'b0, head[sel]} + curRec - REC1;
  wire [REC_W-1:0] physIdx = (physSum >= cfgNrec[sel]) ? physSum - cfgNrec[sel] : physSum;
  wire [LEN_W-1:0] bytePos = sPos + j;
  wire [SAW-1:0] recAddr = {physIdx[REC_W-2:0], bytePos[LEN_W-2:0]};
  wire [SAW-1:0] binAddr = binOff + {{(REC_W-2){1'b0}}, j};
  wire [AW-1:0] memAddr = {sel, (cmd == `RFCH_CMD_UPBIN) ? binAddr : recAddr};
  wire memWe = (state == S_XFER) && (cmd != `RFCH_CMD_RDREC);
  wire [7:0] memRdata;

  rfch_rec_store #(
    .AW(AW)
  ) u_store (
    .clk_sys(clk_sys),
    .we(memWe),
    .addr(memAddr),
    .wdata(dbuf[j[LEN_W-2:0]]),
    .rdata(memRdata)
  );

  // Search direction follows P2 bit0: forward 100, backward 101
  task nextRec;
    begin
      if (p2[`RFCH_P2_BWD] ? (curRec == REC1) : (curRec == cfgNrec[sel])) begin
        state <= S_DONE;
      end else begin
        curRec <= p2[`RFCH_P2_BWD] ? curRec - REC1 : curRec + REC1;
        state <= S_SREC;
      end
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Registers and command engine
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state <= S_IDLE;
      busy <= 1'b0;
      cmd <= `RFCH_CMD_UPBIN;
      p1 <= `RFCH_RST_BYTE;
      p2 <= `RFCH_RST_BYTE;
      lc <= 0;
      le <= `RFCH_RST_BYTE;
      leValid <= 1'b0;
      soMode <= `RFCH_SO_FIRST;
      soVal <= `RFCH_RST_BYTE;
      sel <= 0;
      ptr <= 0;
      ptrSet <= 1'b0;
      result <= `RFCH_R_OK;
      respLen <= 0;
      curRec <= 0;
      pend <= 0;
      pendMove <= 1'b0;
      xLen <= 0;
      sPos <= 0;
      j <= 0;
      binOff <= 0;
      for (k = 0; k < NSLOT; k = k + 1) begin
        cfgSfi[k] <= `RFCH_SFI_CUR;
        cfgType[k] <= `RFCH_FT_TRANS;
        cfgRd[k] <= 1'b0;
        cfgUp[k] <= 1'b0;
        cfgNrec[k] <= 0;
        cfgLen[k] <= 0;
        head[k] <= 0;
      end
      for (k = 0; k < MAXLEN; k = k + 1) begin
        dbuf[k] <= `RFCH_RST_BYTE;
        rbuf[k] <= `RFCH_RST_BYTE;
      end
    end else begin
      if (wrEv) begin
        case (paddr)
          `RFCH_A_CTRL: begin
            cmd <= pwdata[`RFCH_CTRL_CMD +: 2];
            if (pwdata[`RFCH_CTRL_GO]) begin
              busy <= 1'b1;
              state <= S_DEC;
            end
          end
          `RFCH_A_PARAM: begin
            p1 <= pwdata[7:0];
            p2 <= pwdata[`RFCH_PAR_P2 +: 8];
          end
          `RFCH_A_LEN: begin
            lc <= pwdata[LEN_W-1:0];
            le <= pwdata[`RFCH_LEN_LE +: 8];
            leValid <= pwdata[`RFCH_LEN_LEV];
          end
          `RFCH_A_SRCH: begin
            soMode <= pwdata[1:0];
            soVal <= pwdata[`RFCH_SR_VAL +: 8];
          end
          `RFCH_A_SEL: begin
            sel <= pwdata[SLOT_W-1:0];
            if (pwdata[SLOT_W-1:0] != sel) begin
              ptrSet <= 1'b0;
            end
          end
          `RFCH_A_FCFG: begin
            cfgSfi[pwdata[`RFCH_FC_SLOT +: SLOT_W]] <= pwdata[4:0];
            cfgType[pwdata[`RFCH_FC_SLOT +: SLOT_W]] <= pwdata[`RFCH_FC_TYPE +: 2];
            cfgRd[pwdata[`RFCH_FC_SLOT +: SLOT_W]] <= pwdata[`RFCH_FC_RD];
            cfgUp[pwdata[`RFCH_FC_SLOT +: SLOT_W]] <= pwdata[`RFCH_FC_UP];
            cfgNrec[pwdata[`RFCH_FC_SLOT +: SLOT_W]] <= pwdata[`RFCH_FC_NREC +: REC_W];
            cfgLen[pwdata[`RFCH_FC_SLOT +: SLOT_W]] <= pwdata[`RFCH_FC_LEN +: LEN_W];
            head[pwdata[`RFCH_FC_SLOT +: SLOT_W]] <= 0;
            if (pwdata[`RFCH_FC_SLOT +: SLOT_W] == sel) begin
              ptrSet <= 1'b0;
            end
          end
          default: begin
            if (inDbuf) begin
              dbuf[bufIx] <= pwdata[7:0];
            end
          end
        endcase
      end
      case (state)
        S_IDLE: ;
        S_DEC: begin
          result <= dRes;
          respLen <= 0;
          pend <= dRec;
          pendMove <= dMove;
          curRec <= dRec;
          sPos <= 0;
          j <= 0;
          xLen <= dLen;
          binOff <= binOffRaw[SAW-1:0];
          // Failures stop here, before anything is stored or moved
          if (dRes != `RFCH_R_OK) begin
            state <= S_DONE;
          end else begin
            if (tSlot != sel) begin
              sel <= tSlot;
              ptrSet <= 1'b0;
            end
            if (cmd == `RFCH_CMD_UPREC && isCyc) begin
              head[tSlot] <= headDec;
            end
            if (cmd == `RFCH_CMD_RDREC) begin
              respLen <= dLen;
            end
            if (cmd == `RFCH_CMD_SRCH) begin
              state <= S_SREC;
            end else begin
              state <= (dLen == 0) ? S_DONE : S_XFER;
            end
          end
        end
        S_XFER: begin
          if (cmd == `RFCH_CMD_RDREC) begin
            rbuf[j[LEN_W-2:0]] <= memRdata;
          end
          if (j == xLen - 1'b1) begin
            state <= S_DONE;
          end else begin
            j <= j + 1'b1;
          end
        end
        S_SREC: begin
          j <= 0;
          sPos <= (soMode == `RFCH_SO_OFFS) ? soVal[LEN_W-1:0] : {LEN_W{1'b0}};
          if (soMode == `RFCH_SO_OFFS && soVal >= xLen) begin
            nextRec;
          end else begin
            state <= (soMode == `RFCH_SO_CHAR) ? S_SFIND : S_SCMP;
          end
        end
        S_SFIND: begin
          if (memRdata == soVal) begin
            sPos <= j + 1'b1;
            j <= 0;
            state <= S_SCMP;
          end else if (j == xLen - 1'b1) begin
            nextRec;
          end else begin
            j <= j + 1'b1;
          end
        end
        S_SCMP: begin
          if ({1'b0, sPos} + lc > {1'b0, xLen}) begin
            nextRec;
          end else if (memRdata == dbuf[j[LEN_W-2:0]]) begin
            if (j == lc - 1'b1) begin
              if (!pendMove) begin
                pend <= curRec;
                pendMove <= 1'b1;
              end
              // Le of zero is read as the largest request
              if (leValid && (le == 8'h00 || respLen < le)) begin
                rbuf[respLen[LEN_W-2:0]] <= {{(8-REC_W){1'b0}}, curRec};
                respLen <= respLen + 1'b1;
              end
              nextRec;
            end else begin
              j <= j + 1'b1;
            end
          end else begin
            sPos <= sPos + 1'b1;
            j <= 0;
          end
        end
        S_DONE: begin
          if (result == `RFCH_R_OK && pendMove) begin
            ptr <= pend;
            ptrSet <= 1'b1;
          end
          busy <= 1'b0;
          state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule // rfch_top

/* File: verilog/rfch_map.vh */
`ifndef RFCH_MAP_VH
`define RFCH_MAP_VH
// Register byte offsets
`define RFCH_A_CTRL 12'h000
`define RFCH_A_PARAM 12'h004
`define RFCH_A_LEN 12'h008
`define RFCH_A_SRCH 12'h00C
`define RFCH_A_SEL 12'h010
`define RFCH_A_FCFG 12'h014
`define RFCH_A_STAT 12'h018
`define RFCH_A_DBUF 12'h400
`define RFCH_A_RBUF 12'h800
`define RFCH_A_WIN 12'hC00
////////////////////////////////////////////////////////////////////////////////
// Field positions
`define RFCH_CTRL_GO 0
`define RFCH_CTRL_CMD 4
`define RFCH_PAR_P2 8
`define RFCH_P2_BWD 0
`define RFCH_LEN_LE 8
`define RFCH_LEN_LEV 16
`define RFCH_SR_VAL 8
`define RFCH_FC_TYPE 5
`define RFCH_FC_RD 7
`define RFCH_FC_UP 8
`define RFCH_FC_NREC 16
`define RFCH_FC_LEN 24
`define RFCH_FC_SLOT 30
`define RFCH_ST_BUSY 0
`define RFCH_ST_RES 4
`define RFCH_ST_PSET 7
`define RFCH_ST_PTR 8
`define RFCH_ST_RLEN 16
`define RFCH_ST_SEL 24
////////////////////////////////////////////////////////////////////////////////
// Commands, file types, modes, results
`define RFCH_CMD_UPBIN 2'h0
`define RFCH_CMD_RDREC 2'h1
`define RFCH_CMD_UPREC 2'h2
`define RFCH_CMD_SRCH 2'h3
`define RFCH_FT_TRANS 2'h0
`define RFCH_FT_LIN 2'h1
`define RFCH_FT_CYC 2'h2
`define RFCH_M_NEXT 3'h2
`define RFCH_M_PREV 3'h3
`define RFCH_M_ABS 3'h4
`define RFCH_M_FWD 3'h4
`define RFCH_M_BWD 3'h5
`define RFCH_SO_FIRST 2'h0
`define RFCH_SO_OFFS 2'h1
`define RFCH_SO_CHAR 2'h2
`define RFCH_SFI_CUR 5'h00
`define RFCH_SFI_RFU 5'h1F
`define RFCH_BIN_SFI 3'h4
`define RFCH_R_OK 3'h0
`define RFCH_R_NODATA 3'h1
`define RFCH_R_DENIED 3'h2
`define RFCH_R_BADP 3'h3
`define RFCH_R_NOFILE 3'h4
`define RFCH_R_WSTRUCT 3'h5
////////////////////////////////////////////////////////////////////////////////
// Reset values
`define RFCH_RST_BYTE 8'h00
`define RFCH_RST_WORD 32'h0000_0000
`endif

/* File: verilog/rfch_rec_store.v */
`timescale 1ns/10ps
module rfch_rec_store #(
  parameter AW = 11
) (
  // Clock
  input wire clk_sys,
  // Byte port
  input wire we,
  input wire [AW-1:0] addr,
  input wire [7:0] wdata,
  output wire [7:0] rdata
);
  // Asynchronous read keeps the search at one byte per clock
  reg [7:0] mem [0:(1<<AW)-1];

  always @(posedge clk_sys) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end

  assign rdata = mem[addr];
endmodule // rfch_rec_store

/* File: testbench/rfch_top_asserts.sv */
`timescale 1ns/10ps
`include "rfch_map.vh"
module rfch_top_asserts (
  // Clock and reset
  input wire clk_sys,
  input wire resetn,
  // APB
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // Settled status reads only
  wire stRd = pready && !pwrite && paddr == `RFCH_A_STAT && !prdata[0];
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_answer_second_access: assert property (psel && !penable |-> ##2 pready)
    else $error("answer not in second access cycle");
  a_unmapped_refused: assert property (pready && paddr == 12'h01C |-> pslverr)
    else $error("unmapped access accepted");
  a_status_read_only: assert property (pready && pwrite && paddr == `RFCH_A_STAT |-> pslverr)
    else $error("status write accepted");
  a_refused_read_zero: assert property (pready && pslverr && !pwrite |-> prdata == 0)
    else $error("refused read returned data");
  a_data_holds: assert property (!pready |-> $stable(prdata))
    else $error("read data changed between accesses");
  a_fail_no_data: assert property (stRd && prdata[6:4] != 0 |-> prdata[21:16] == 0)
    else $error("failed command returned data");
  a_pointer_nonzero: assert property (stRd && prdata[7] |-> prdata[12:8] != 0)
    else $error("record pointer set to zero");
endmodule // rfch_top_asserts

/* File: testbench/rfch_apb_master.sv */
`timescale 1ns/10ps
module rfch_apb_master (
  // Clock
  input wire clk_sys,
  // APB master side
  output reg psel = 1'b0,
  output reg penable = 1'b0,
  output reg pwrite = 1'b0,
  output reg [11:0] paddr = 12'h000,
  output reg [31:0] pwdata = 32'h0000_0000,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr
);
  // Called right after a rising edge; returns one edge after release
  task xfer(input w, input [11:0] a, input [31:0] d, output [31:0] q, output e);
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      // No cycle limit here: a hang is ended by the bench watchdog
      while (pready !== 1'b1) begin
        @(posedge clk_sys);
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Released lines must not look like a held request
      paddr <= ~a;
      pwdata <= ~d;
      @(posedge clk_sys);
    end
  endtask
endmodule // rfch_apb_master

/* File: testbench/testbench.sv */
`timescale 1ns/10ps
`include "rfch_map.vh"
bind rfch_top rfch_top_asserts u_chk (.clk_sys(clk_sys), .resetn(resetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr));
module testbench;
  localparam [1:0] RD = `RFCH_CMD_RDREC;
  localparam [1:0] UP = `RFCH_CMD_UPREC;
  localparam [2:0] OK = `RFCH_R_OK;
  localparam [2:0] ND = `RFCH_R_NODATA;
  localparam [11:0] R0 = `RFCH_A_RBUF;
  localparam [11:0] R1 = `RFCH_A_RBUF + 12'h004;
  reg clk_sys = 1'b0;
  reg resetn = 1'b0;
  wire psel, penable, pwrite, pready, pslverr;
  wire [11:0] paddr;
  wire [31:0] pwdata, prdata;
  reg [31:0] q;
  reg e;
  reg [7:0] i;
  integer err_count = 0;
  integer n_tests = 0;
  rfch_top u_dut (.clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  rfch_apb_master u_mst (.clk_sys(clk_sys), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end
  //////////////////////////////////////////////////////////////////////////////
  task print_verdict;
    begin
      $display("Checks %0d, errors %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
        $display("RESULT: PASS");
      end else begin
        $display("RESULT: FAIL");
      end
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [11:0] a, input [31:0] d);
    u_mst.xfer(1'b1, a, d, q, e);
  endtask
  task rchk(input [11:0] a, input [7:0] x);
    begin
      u_mst.xfer(1'b0, a, 32'h0000_0000, q, e);
      chk(q, {24'h00_0000, x});
    end
  endtask
  // Expected pointer given as {set, number}; number must be zero when unset
  task cmd(input [1:0] c, input [15:0] par, input [31:0] len, input [2:0] r, input [5:0] p);
    begin
      wr(`RFCH_A_PARAM, {16'h0000, par});
      wr(`RFCH_A_LEN, len);
      wr(`RFCH_A_CTRL, {26'h000_0000, c, 4'h1});
      q = 32'h0000_0001;
      while (q[0] !== 1'b0) begin
        u_mst.xfer(1'b0, `RFCH_A_STAT, 32'h0000_0000, q, e);
      end
      chk({23'h00_0000, q[7], q[7] ? q[12:8] : 5'h00, q[6:4]}, {23'h00_0000, p, r});
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count = err_count + 1;
    print_verdict;
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rchk(`RFCH_A_STAT, 8'h00);
    wr(`RFCH_A_FCFG, 32'h0203_01A1);
    wr(`RFCH_A_FCFG, 32'h4203_01C2);
    wr(`RFCH_A_FCFG, 32'h8203_0023);
    wr(`RFCH_A_FCFG, 32'hC000_0104);
    for (i = 1; i < 4; i = i + 1) begin
      wr(`RFCH_A_DBUF, {24'h00_0000, i});
      wr(`RFCH_A_DBUF + 12'h004, {24'h00_0000, i + 8'h10});
      cmd(UP, {8'h04, i}, 32'h0000_0002, OK, 6'h00);
    end
    for (i = 1; i < 5; i = i + 1) begin
      cmd(RD, 16'h0200, 0, (i == 4) ? ND : OK, {1'b1, (i == 4) ? 5'h03 : i[4:0]});
      if (i < 4) rchk(R1, i + 8'h10);
    end
    cmd(RD, 16'h0300, 0, OK, 6'h22);
    cmd(RD, 16'h0300, 0, OK, 6'h21);
    cmd(RD, 16'h0300, 0, ND, 6'h21);
    cmd(RD, 16'h0400, 0, OK, 6'h21);
    rchk(R1, 8'h11);
    cmd(RD, 16'h0403, 0, OK, 6'h21);
    rchk(R1, 8'h13);
    cmd(RD, 16'h1C01, 0, `RFCH_R_DENIED, 6'h21);
    chk({30'h0000_0000, q[25:24]}, 0);
    cmd(UP, 16'h02FF, 2, OK, 6'h22);
    cmd(UP, 16'h0200, 2, OK, 6'h23);
    cmd(UP, 16'h0200, 2, ND, 6'h23);
    wr(`RFCH_A_SEL, 1);
    // Status after the reselect shows slot 1 selected and the pointer set flag dropped
    u_mst.xfer(1'b0, `RFCH_A_STAT, 32'h0000_0000, q, e);
    chk({29'h0000_0000, q[25:24], q[7]}, 32'h0000_0002);
    for (i = 1; i < 4; i = i + 1) begin
      wr(`RFCH_A_DBUF, {24'h00_0000, i + 8'hA0});
      cmd(UP, 16'h0300, 2, OK, 6'h21);
    end
    cmd(UP, 16'h0200, 2, `RFCH_R_BADP, 6'h21);
    cmd(RD, 16'h0401, 0, OK, 6'h21);
    rchk(R0, 8'hA3);
    cmd(RD, 16'h0300, 0, OK, 6'h23);
    rchk(R0, 8'hA1);
    cmd(RD, 16'h0200, 0, OK, 6'h21);
    rchk(R0, 8'hA3);
    wr(`RFCH_A_SEL, 0);
    cmd(RD, 16'h0300, 0, OK, 6'h23);
    rchk(R1, 8'h13);
    wr(`RFCH_A_DBUF, 32'h0000_0013);
    wr(`RFCH_A_SRCH, 32'h0000_0101);
    cmd(`RFCH_CMD_SRCH, 16'h0401, 32'h0001_0001, OK, 6'h22);
    chk({26'h000_0000, q[21:16]}, 2);
    rchk(R1, 8'h03);
    cmd(`RFCH_CMD_SRCH, 16'h0401, 32'h0001_0101, OK, 6'h22);
    chk({26'h000_0000, q[21:16]}, 1);
    cmd(`RFCH_CMD_SRCH, 16'h0401, 32'h0000_0001, OK, 6'h22);
    chk({26'h000_0000, q[21:16]}, 0);
    wr(`RFCH_A_SRCH, 32'h0000_0302);
    cmd(`RFCH_CMD_SRCH, 16'h0503, 32'h0001_0001, OK, 6'h23);
    rchk(R1, 8'h02);
    cmd(RD, 16'hFC01, 0, `RFCH_R_BADP, 6'h23);
    cmd(RD, 16'h2C01, 0, `RFCH_R_NOFILE, 6'h23);
    cmd(UP, 16'h0300, 2, OK, 6'h22);
    cmd(`RFCH_CMD_UPBIN, 16'h1000, 2, `RFCH_R_WSTRUCT, 6'h22);
    cmd(`RFCH_CMD_UPBIN, 16'h1084, 2, OK, 6'h00);
    chk({30'h0000_0000, q[25:24]}, 3);
    wr(`RFCH_A_STAT, 32'h0000_0000);
    chk({31'h0000_0000, e}, 1);
    rchk(12'h01C, 8'h00);
    chk({31'h0000_0000, e}, 1);
    print_verdict;
  end
endmodule // testbench
